// *** common/oafe_pkg.sv ***
package oafe_pkg;

	// register byte addresses on the apb window
	localparam logic [11:0] ADDR_SWITCH_MODE = 12'h000;
	localparam logic [11:0] ADDR_FIRST_GAIN  = 12'h004;
	localparam logic [11:0] ADDR_SECOND_GAIN = 12'h008;
	localparam logic [11:0] ADDR_AMP0_CTRL   = 12'h00c;
	localparam logic [11:0] ADDR_AMP1_CTRL   = 12'h010;
	localparam logic [11:0] ADDR_AMP0_TRIM   = 12'h014;
	localparam logic [11:0] ADDR_AMP1_TRIM   = 12'h018;

	// writable masks per register
	localparam logic [7:0] MASK_SWITCH_MODE = 8'h7f;
	localparam logic [7:0] MASK_FIRST_GAIN  = 8'h3f;
	localparam logic [7:0] MASK_SECOND_GAIN = 8'hff;
	localparam logic [7:0] MASK_AMP_CTRL    = 8'h43;
	localparam logic [7:0] MASK_AMP_TRIM    = 8'hff;

	// reset values
	localparam logic [7:0] RST_SWITCH_MODE = 8'h00;
	localparam logic [7:0] RST_FIRST_GAIN  = 8'h00;
	localparam logic [7:0] RST_SECOND_GAIN = 8'h00;
	localparam logic [7:0] RST_AMP_CTRL    = 8'h00;
	localparam logic [7:0] RST_AMP_TRIM    = 8'h20;

	// field positions
	localparam int COUPLING_LSB   = 5;
	localparam int SWITCH_BITS    = 5;
	localparam int CODE_BITS      = 6;
	localparam int THIRD_RES_LSB  = 6;
	localparam int AMP_ENABLE_BIT = 6;
	localparam int AMP_STATUS_BIT = 5;
	localparam int CAL_MODE_BIT   = 7;
	localparam int CAL_REF_BIT    = 6;
	localparam int CPL_BITS       = 2;
	localparam int THIRD_RES_BITS = 2;
	localparam int BW_LSB         = 0;
	localparam int BW_BITS        = 2;

	// coupling mode encodings
	typedef enum logic [1:0] {
		OAFE_CPL_EXT0 = 2'h0,
		OAFE_CPL_AC   = 2'h1,
		OAFE_CPL_EXT1 = 2'h2,
		OAFE_CPL_DC   = 2'h3
	} oafe_coupling_t;

endpackage

// *** hdl/oafe_regs.sv ***
`timescale 1ns/1ps
module oafe_regs #(
	parameter int ADDR_W = 12
) (
	input  wire logic              i_clk,          // system clock, 100 MHz
	input  wire logic              i_rst_n,        // sync reset, active low
	input  wire logic              i_psel,         // apb select
	input  wire logic              i_penable,      // apb access phase
	input  wire logic              i_pwrite,       // apb direction
	input  wire logic [ADDR_W-1:0] i_paddr,        // apb byte address
	input  wire logic [31:0]       i_pwdata,       // apb write data
	input  wire logic [3:0]        i_pstrb,        // apb byte strobes
	input  wire logic [1:0]        i_amp_out,      // raw amplifier outputs
	output logic      [31:0]       o_prdata,       // apb read data
	output logic                   o_pready,       // apb ready
	output logic                   o_pslverr,      // apb error, unmapped
	output logic      [4:0]        o_switch_close, // switch bits four..zero
	output logic                   o_ac_sw_close,  // both ac coupling switches
	output logic                   o_dc_sw_close,  // both bias switches
	output logic                   o_ext_mode,     // external coupling mode
	output logic      [5:0]        o_first_res,    // first resistor code
	output logic      [5:0]        o_second_res,   // second resistor code
	output logic      [1:0]        o_third_res,    // third resistor code
	output logic      [1:0]        o_amp_enable,   // per amplifier enable
	output logic      [3:0]        o_amp_bw,       // bandwidth, amp1 high
	output logic      [1:0]        o_cal_mode,     // calibration mode
	output logic      [1:0]        o_cal_ref,      // calibration reference
	output logic      [11:0]       o_trim_code     // trim codes, amp1 high
);

	// the map ends at 0x018 and is decoded on twelve bits; widths below five lose registers and widths above twelve alias them
	if (ADDR_W < 5 || ADDR_W > 12) begin : g_bad_addr_w
		$error("oafe_regs: ADDR_W must lie between 5 and 12");
	end

	// register storage
	logic [7:0] sw_r, g0_r, g1_r, c0_r, c1_r, t0_r, t1_r;
	logic [7:0] sw_nxt, g0_nxt, g1_nxt, c0_nxt, c1_nxt, t0_nxt, t1_nxt;
	logic [1:0] amp_sync;
	logic [1:0] status_r;

	oafe_sync #(
		.WIDTH(2)
	) u_sync (
		.i_clk  (i_clk),
		.i_rst_n(i_rst_n),
		.i_async(i_amp_out),
		.o_sync (amp_sync)
	);

	// compare of the decoded address against one register offset
	function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] base);
		addr_hit = (a == base);
	endfunction

	// apb decode; every access completes in its first access cycle
	wire        setup_ph = i_psel && !i_penable;
	wire        access   = i_psel && i_penable;
	wire        wr_low   = access && i_pwrite && i_pstrb[0];
	wire [11:0] addr     = 12'(i_paddr);
	wire        hit_sw   = addr_hit(addr, oafe_pkg::ADDR_SWITCH_MODE);
	wire        hit_g0   = addr_hit(addr, oafe_pkg::ADDR_FIRST_GAIN);
	wire        hit_g1   = addr_hit(addr, oafe_pkg::ADDR_SECOND_GAIN);
	wire        hit_c0   = addr_hit(addr, oafe_pkg::ADDR_AMP0_CTRL);
	wire        hit_c1   = addr_hit(addr, oafe_pkg::ADDR_AMP1_CTRL);
	wire        hit_t0   = addr_hit(addr, oafe_pkg::ADDR_AMP0_TRIM);
	wire        hit_t1   = addr_hit(addr, oafe_pkg::ADDR_AMP1_TRIM);
	wire        mapped   = hit_sw | hit_g0 | hit_g1 | hit_c0 | hit_c1 | hit_t0 | hit_t1;

	// masked merge so unimplemented bits never store a write
	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd,
	                                     input logic [7:0] mask, input logic en);
		merge = en ? (wd & mask) : old;
	endfunction

	assign sw_nxt = merge(sw_r, i_pwdata[7:0], oafe_pkg::MASK_SWITCH_MODE, wr_low && hit_sw);
	assign g0_nxt = merge(g0_r, i_pwdata[7:0], oafe_pkg::MASK_FIRST_GAIN, wr_low && hit_g0);
	assign g1_nxt = merge(g1_r, i_pwdata[7:0], oafe_pkg::MASK_SECOND_GAIN, wr_low && hit_g1);
	assign c0_nxt = merge(c0_r, i_pwdata[7:0], oafe_pkg::MASK_AMP_CTRL, wr_low && hit_c0);
	assign c1_nxt = merge(c1_r, i_pwdata[7:0], oafe_pkg::MASK_AMP_CTRL, wr_low && hit_c1);
	assign t0_nxt = merge(t0_r, i_pwdata[7:0], oafe_pkg::MASK_AMP_TRIM, wr_low && hit_t0);
	assign t1_nxt = merge(t1_r, i_pwdata[7:0], oafe_pkg::MASK_AMP_TRIM, wr_low && hit_t1);

	// switch and coupling register; a write lands at the access edge
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			sw_r <= oafe_pkg::RST_SWITCH_MODE;
		end else begin
			sw_r <= sw_nxt;
		end
	end

	// first gain register
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			g0_r <= oafe_pkg::RST_FIRST_GAIN;
		end else begin
			g0_r <= g0_nxt;
		end
	end

	// second gain register
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			g1_r <= oafe_pkg::RST_SECOND_GAIN;
		end else begin
			g1_r <= g1_nxt;
		end
	end

	// amplifier zero control; the status bit is never stored here
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			c0_r <= oafe_pkg::RST_AMP_CTRL;
		end else begin
			c0_r <= c0_nxt;
		end
	end

	// amplifier one control
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			c1_r <= oafe_pkg::RST_AMP_CTRL;
		end else begin
			c1_r <= c1_nxt;
		end
	end

	// amplifier zero trim; resets to mid-scale so an uncalibrated part starts centred
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			t0_r <= oafe_pkg::RST_AMP_TRIM;
		end else begin
			t0_r <= t0_nxt;
		end
	end

	// amplifier one trim
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			t1_r <= oafe_pkg::RST_AMP_TRIM;
		end else begin
			t1_r <= t1_nxt;
		end
	end

	// status bit follows the amplifier only in calibration mode
	wire [1:0] cal_now = {t1_r[oafe_pkg::CAL_MODE_BIT], t0_r[oafe_pkg::CAL_MODE_BIT]};
	wire [1:0] status_nxt = amp_sync & cal_now;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) status_r <= 2'h0;
		else          status_r <= status_nxt;
	end

	// control registers with the read-only status bit inserted
	function automatic logic [7:0] ctrl_view(input logic [7:0] ctrl, input logic st);
		logic [7:0] v;
		v = ctrl & oafe_pkg::MASK_AMP_CTRL;
		v[oafe_pkg::AMP_STATUS_BIT] = st;
		ctrl_view = v;
	endfunction

	// read mux; reserved bits and unmapped addresses read as zero
	// status is gated again by the live mode bit, else a back-to-back read could see a stale one
	wire [7:0] rd_byte =
		hit_sw ? sw_r :
		hit_g0 ? g0_r :
		hit_g1 ? g1_r :
		hit_c0 ? ctrl_view(c0_r, status_r[0] && cal_now[0]) :
		hit_c1 ? ctrl_view(c1_r, status_r[1] && cal_now[1]) :
		hit_t0 ? t0_r :
		hit_t1 ? t1_r : 8'h00;

	// apb answer; the setup edge registers it so that it stands in the first access cycle
	wire        ready_nxt = setup_ph;
	wire        err_nxt   = setup_ph && !mapped;
	wire [31:0] rdata_nxt = (setup_ph && !i_pwrite) ? 32'(rd_byte) : 32'h0000_0000;

	// ready pulse; a master that keeps penable high gets no second one
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_pready <= 1'b0;
		end else begin
			o_pready <= ready_nxt;
		end
	end

	// error pulse beside ready for unmapped addresses
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_pslverr <= 1'b0;
		end else begin
			o_pslverr <= err_nxt;
		end
	end

	// read data stands only with ready, zero otherwise so old bytes never linger on the bus
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_prdata <= 32'h0000_0000;
		end else begin
			o_prdata <= rdata_nxt;
		end
	end

	// coupling decode {ac, dc, ext}, shared by the stored value and the reset value of the pins
	function automatic logic [2:0] cpl_decode(input logic [7:0] sw);
		logic [1:0] fld;
		fld = sw[oafe_pkg::COUPLING_LSB +: oafe_pkg::CPL_BITS];
		cpl_decode[2] = (fld == oafe_pkg::OAFE_CPL_AC);
		cpl_decode[1] = (fld == oafe_pkg::OAFE_CPL_DC);
		cpl_decode[0] = !cpl_decode[2] && !cpl_decode[1];
	endfunction

	// pin values during reset, taken from the register reset values so the two never disagree
	localparam logic [2:0]  CPL_RST        = cpl_decode(oafe_pkg::RST_SWITCH_MODE);
	localparam logic [4:0]  SW_PINS_RST    = oafe_pkg::RST_SWITCH_MODE[oafe_pkg::SWITCH_BITS-1:0];
	localparam logic [5:0]  FIRST_RES_RST  = oafe_pkg::RST_FIRST_GAIN[oafe_pkg::CODE_BITS-1:0];
	localparam logic [5:0]  SECOND_RES_RST = oafe_pkg::RST_SECOND_GAIN[oafe_pkg::CODE_BITS-1:0];
	localparam logic [1:0]  THIRD_RES_RST  =
		oafe_pkg::RST_SECOND_GAIN[oafe_pkg::THIRD_RES_LSB +: oafe_pkg::THIRD_RES_BITS];
	localparam logic [1:0]  AMP_EN_RST     = {2{oafe_pkg::RST_AMP_CTRL[oafe_pkg::AMP_ENABLE_BIT]}};
	localparam logic [3:0]  AMP_BW_RST     =
		{2{oafe_pkg::RST_AMP_CTRL[oafe_pkg::BW_LSB +: oafe_pkg::BW_BITS]}};
	localparam logic [1:0]  CAL_MODE_RST   = {2{oafe_pkg::RST_AMP_TRIM[oafe_pkg::CAL_MODE_BIT]}};
	localparam logic [1:0]  CAL_REF_RST    = {2{oafe_pkg::RST_AMP_TRIM[oafe_pkg::CAL_REF_BIT]}};
	localparam logic [11:0] TRIM_RST       = {2{oafe_pkg::RST_AMP_TRIM[oafe_pkg::CODE_BITS-1:0]}};

	// live field views, amplifier one in the high part
	wire [2:0]  cpl_now     = cpl_decode(sw_r);
	wire [1:0]  amp_en_now  = {c1_r[oafe_pkg::AMP_ENABLE_BIT], c0_r[oafe_pkg::AMP_ENABLE_BIT]};
	wire [3:0]  bw_now      = {c1_r[oafe_pkg::BW_LSB +: oafe_pkg::BW_BITS],
	                           c0_r[oafe_pkg::BW_LSB +: oafe_pkg::BW_BITS]};
	wire [1:0]  cal_ref_now = {t1_r[oafe_pkg::CAL_REF_BIT], t0_r[oafe_pkg::CAL_REF_BIT]};
	wire [11:0] trim_now    = {t1_r[oafe_pkg::CODE_BITS-1:0], t0_r[oafe_pkg::CODE_BITS-1:0]};

	// the analog pins follow the stored bits one edge after the write; each pin set has its own flops

	// switch bits four..zero; bit one passes as written, keeping it off in dc mode is software's duty
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_switch_close <= SW_PINS_RST;
		end else begin
			o_switch_close <= sw_r[oafe_pkg::SWITCH_BITS-1:0];
		end
	end

	// coupling pins; exactly one of the three is high in every mode
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_ac_sw_close <= CPL_RST[2];
			o_dc_sw_close <= CPL_RST[1];
			o_ext_mode    <= CPL_RST[0];
		end else begin
			o_ac_sw_close <= cpl_now[2];
			o_dc_sw_close <= cpl_now[1];
			o_ext_mode    <= cpl_now[0];
		end
	end

	// first feedback resistor code
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_first_res <= FIRST_RES_RST;
		end else begin
			o_first_res <= g0_r[oafe_pkg::CODE_BITS-1:0];
		end
	end

	// second feedback resistor code
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_second_res <= SECOND_RES_RST;
		end else begin
			o_second_res <= g1_r[oafe_pkg::CODE_BITS-1:0];
		end
	end

	// third resistor code from the top pair of the second gain register
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_third_res <= THIRD_RES_RST;
		end else begin
			o_third_res <= g1_r[oafe_pkg::THIRD_RES_LSB +: oafe_pkg::THIRD_RES_BITS];
		end
	end

	// amplifier enables
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_amp_enable <= AMP_EN_RST;
		end else begin
			o_amp_enable <= amp_en_now;
		end
	end

	// bandwidth codes
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_amp_bw <= AMP_BW_RST;
		end else begin
			o_amp_bw <= bw_now;
		end
	end

	// normal or calibration operation per amplifier
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_cal_mode <= CAL_MODE_RST;
		end else begin
			o_cal_mode <= cal_now;
		end
	end

	// calibration reference per amplifier
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_cal_ref <= CAL_REF_RST;
		end else begin
			o_cal_ref <= cal_ref_now;
		end
	end

	// trim codes are driven raw; the bound search and the averaging are left to software
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_trim_code <= TRIM_RST;
		end else begin
			o_trim_code <= trim_now;
		end
	end

endmodule

// *** hdl/oafe_sync.sv ***
`timescale 1ns/1ps
// two-flop synchroniser for the analog comparator levels
module oafe_sync #(
	parameter int WIDTH = 2
) (
	input  wire logic             i_clk,   // system clock
	input  wire logic             i_rst_n, // sync reset, active low
	input  wire logic [WIDTH-1:0] i_async, // level from outside the domain
	output logic      [WIDTH-1:0] o_sync   // synchronised level
);

	// a zero-width synchroniser has nothing to carry
	if (WIDTH < 1) begin : g_bad_width
		$error("oafe_sync: WIDTH must be at least one");
	end

	logic [WIDTH-1:0] meta_r;

	// first stage is read only by the second stage
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			meta_r <= '0;
			o_sync <= '0;
		end else begin
			meta_r <= i_async;
			o_sync <= meta_r;
		end
	end

endmodule

// *** verification/oafe_monitor.sv ***
`timescale 1ns/1ps
// watches the bus answer and the control pins of the register bank
module oafe_monitor #(parameter int ADDR_W = 12) (
	input wire logic              i_clk,          // clock
	input wire logic              i_rst_n,        // reset, low
	input wire logic              i_psel,         // select
	input wire logic              i_penable,      // access
	input wire logic              i_pwrite,       // direction
	input wire logic [ADDR_W-1:0] i_paddr,        // address
	input wire logic [31:0]       i_pwdata,       // write data
	input wire logic [3:0]        i_pstrb,        // strobes
	input wire logic [31:0]       o_prdata,       // read data
	input wire logic              o_pready,       // ready
	input wire logic              o_pslverr,      // error
	input wire logic [4:0]        o_switch_close, // switches
	input wire logic              o_ac_sw_close,  // ac pair
	input wire logic              o_dc_sw_close,  // bias pair
	input wire logic              o_ext_mode,     // external
	input wire logic [1:0]        o_cal_mode,     // cal mode
	input wire logic [11:0]       o_trim_code     // trims
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// accepted write; pins follow one edge after the register, so checks look two edges on
	wire acc = i_psel && i_penable && o_pready && i_pwrite && i_pstrb[0];
	a_ready_setup: assert property (i_psel && !i_penable |=> o_pready) else $error("no ready after setup");
	a_ready_pulse: assert property (o_pready |=> !o_pready) else $error("ready held");
	a_mode_onehot: assert property ($onehot({o_ac_sw_close, o_dc_sw_close, o_ext_mode})) else $error("mode");
	a_switch_follow: assert property (acc && i_paddr == oafe_pkg::ADDR_SWITCH_MODE |=> ##1
		o_switch_close == $past(i_pwdata[4:0], 2)) else $error("switch pins");
	a_dc_follow: assert property (acc && i_paddr == oafe_pkg::ADDR_SWITCH_MODE |=> ##1
		o_dc_sw_close == (&$past(i_pwdata[6:5], 2))) else $error("bias pair");
	a_trim_follow: assert property (acc && i_paddr == oafe_pkg::ADDR_AMP0_TRIM |=> ##1
		{o_cal_mode[0], o_trim_code[5:0]} == {$past(i_pwdata[7], 2), $past(i_pwdata[5:0], 2)}) else $error("trim");
	a_status_gated: assert property (o_pready && !i_pwrite && i_paddr == oafe_pkg::ADDR_AMP0_CTRL &&
		!o_cal_mode[0] && !$past(o_cal_mode[0]) |-> !o_prdata[5]) else $error("status not low");
	a_rdata_clean: assert property (o_prdata[31:8] == 24'h0 && (o_pready || o_prdata == 32'h0)) else $error("rdata");
	a_err_ready: assert property (o_pslverr |-> o_pready) else $error("error without ready");
	a_reset_trim: assert property ($rose(i_rst_n) |-> o_trim_code == 12'h820 && o_ext_mode) else $error("reset");
endmodule
bind oafe_regs oafe_monitor #(.ADDR_W(ADDR_W)) u_mon (.i_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr,
	.i_pwdata, .i_pstrb, .o_prdata, .o_pready, .o_pslverr, .o_switch_close, .o_ac_sw_close, .o_dc_sw_close,
	.o_ext_mode, .o_cal_mode, .o_trim_code);

// *** verification/tb.sv ***
`timescale 1ns/1ps
`define CHK(n, x, g) begin samples_checked++; if ((g) !== (x)) begin err_total++; $display("BAD %s exp %h got %h", n, x, g); end end
module tb;
	localparam logic [11:0] SW = oafe_pkg::ADDR_SWITCH_MODE, G0 = oafe_pkg::ADDR_FIRST_GAIN;
	localparam logic [11:0] G1 = oafe_pkg::ADDR_SECOND_GAIN, C0 = oafe_pkg::ADDR_AMP0_CTRL;
	localparam logic [11:0] C1 = oafe_pkg::ADDR_AMP1_CTRL, T0 = oafe_pkg::ADDR_AMP0_TRIM, T1 = oafe_pkg::ADDR_AMP1_TRIM;
	logic        i_clk, i_rst_n, i_psel, i_penable, i_pwrite, o_pready, o_pslverr, o_ac_sw_close, o_dc_sw_close;
	logic        o_ext_mode, e, s;
	logic [11:0] i_paddr, o_trim_code;
	logic [31:0] i_pwdata, o_prdata, r;
	logic [3:0]  i_pstrb, o_amp_bw;
	logic [1:0]  i_amp_out, o_third_res, o_amp_enable, o_cal_mode, o_cal_ref;
	logic [4:0]  o_switch_close;
	logic [5:0]  o_first_res, o_second_res;
	int          err_total, samples_checked, c, lo;
	oafe_regs uut (.i_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb, .i_amp_out,
		.o_prdata, .o_pready, .o_pslverr, .o_switch_close, .o_ac_sw_close, .o_dc_sw_close, .o_ext_mode,
		.o_first_res, .o_second_res, .o_third_res, .o_amp_enable, .o_amp_bw, .o_cal_mode, .o_cal_ref, .o_trim_code);
	initial forever #5 i_clk = ~i_clk;
	// amplifier one behaves as a comparator that flips at trim code 23
	always @(posedge i_clk) i_amp_out[1] <= (o_trim_code[11:6] >= 6'd23);
	// one apb transfer; request held until ready is seen, then released
	task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
		int n;
		{i_psel, i_pwrite, i_paddr, i_pwdata} <= {1'b1, w, a, d};
		@(posedge i_clk);
		i_penable <= 1'b1;
		n = 0;
		do @(posedge i_clk); while (o_pready !== 1'b1 && ++n < 16);
		if (o_pready !== 1'b1) begin
			err_total++;
			end_of_test();
		end
		{r, e} = {o_prdata, o_pslverr};
		{i_psel, i_penable} <= 2'b00;
		@(posedge i_clk);
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] x);
		xfer(a, 1'b0, 32'h0);
		`CHK("readback", x, r)
		`CHK("read error", 1'b0, e)
	endtask
	// status sampling waits out the two sync flops and the status flop
	task automatic step(input int k);
		xfer(T1, 1'b1, 32'hc0 | k);
		repeat (4) @(posedge i_clk);
		xfer(C1, 1'b0, 32'h0);
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// main sequence
	initial begin
		{i_clk, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata, i_rst_n} = '0;
		{i_pstrb, i_amp_out, err_total, samples_checked} = {4'h1, 2'h1, 32'h0, 32'h0};
		repeat (5) @(posedge i_clk);
		i_rst_n <= 1'b1;
		rchk(T1, 32'h20);
		rchk(G1, 32'h0);
		// every coupling code, unused bit seven written high, switch bit one kept off
		for (c = 0; c < 4; c++) begin
			xfer(SW, 1'b1, 32'h95 | (c << 5));
			@(posedge i_clk);
			`CHK("switches", 5'h15, o_switch_close)
			`CHK("coupling", {c == 1, c == 3, c[0] == 0}, {o_ac_sw_close, o_dc_sw_close, o_ext_mode})
			rchk(SW, 32'h15 | (c << 5));
		end
		xfer(G0, 1'b1, 32'hff);
		xfer(G1, 1'b1, 32'hb5);
		@(posedge i_clk);
		`CHK("gains", {6'h3f, 2'h2, 6'h35}, {o_first_res, o_third_res, o_second_res})
		rchk(G0, 32'h3f);
		// a write with byte strobe zero must leave the register alone
		i_pstrb <= 4'h0;
		xfer(G0, 1'b1, 32'h01);
		i_pstrb <= 4'h1;
		rchk(G0, 32'h3f);
		// amplifier zero output is high, but status stays low outside calibration
		xfer(C0, 1'b1, 32'hff);
		xfer(C1, 1'b1, 32'h41);
		@(posedge i_clk);
		`CHK("amp controls", {2'h3, 4'h7}, {o_amp_enable, o_amp_bw})
		rchk(C0, 32'h43);
		xfer(T0, 1'b1, 32'h8a);
		repeat (4) @(posedge i_clk);
		`CHK("calibration", {2'h1, 2'h0, 6'h0a}, {o_cal_mode, o_cal_ref, o_trim_code[5:0]})
		rchk(C0, 32'h63);
		// offset search on amplifier one: up from zero, down from the top, then the average
		step(0);
		s = r[5];
		for (c = 1; c < 64 && r[5] === s; c++) step(c);
		lo = c - 1;
		`CHK("low bound", 23, lo)
		step(63);
		s = r[5];
		for (c = 62; c >= 0 && r[5] === s; c--) step(c);
		`CHK("high bound", 22, c + 1)
		xfer(T1, 1'b1, 32'hc0 | ((lo + c + 1) / 2));
		@(posedge i_clk);
		`CHK("final trim", {2'h2, 6'd22}, {o_cal_ref, o_trim_code[11:6]})
		// unmapped address: write ignored, read zero with error
		xfer(12'h01c, 1'b1, 32'hff);
		`CHK("unmapped write", 1'b1, e)
		xfer(12'h01c, 1'b0, 32'h0);
		`CHK("unmapped read", 33'h100000000, {e, r})
		// reset in mid-run restores power-on values
		i_rst_n <= 1'b0;
		repeat (5) @(posedge i_clk);
		`CHK("reset pins", {1'b1, 12'h820, 5'h0}, {o_ext_mode, o_trim_code, o_switch_close})
		i_rst_n <= 1'b1;
		rchk(G0, 32'h0);
		end_of_test();
	end
endmodule
